// ===== tec8_consts.vh
// constants and contract for the 8-bit timer/event counter
`ifndef TEC8_CONSTS_VH
`define TEC8_CONSTS_VH
// register indices; byte address is four times the index
`define TEC8_OFS_COUNT    10'h00D
`define TEC8_OFS_CTRL     10'h00E
`define TEC8_OFS_INTERRUPT_CONTROL_REG     10'h010
`define TEC8_IDX_WIDTH    12
`define TEC8_BIT_PSC_LO   0
`define TEC8_BIT_EDGE     3
`define TEC8_BIT_ENABLE   4
`define TEC8_BIT_MODE_LO  6
`define TEC8_BIT_IRQ_EN   0
`define TEC8_BIT_FLAG     5
`define TEC8_CTRL_RESET   8'h08
`define TEC8_CTRL_MASK    8'hDF
`define TEC8_MODE_EVENT   2'b01
`define TEC8_MODE_TIMER   2'b10
`define TEC8_MODE_PULSE   2'b11
`define TEC8_PSC_WIDTH    8
`endif

// ===== tec8_prescaler.v
// prescaler producing one-cycle enable pulses of the internal count rate
`include "tec8_consts.vh"
`default_nettype none
module tec8_prescaler #(
   parameter WIDTH = `TEC8_PSC_WIDTH
) (
   input  wire         i_sys_clk,
   input  wire         i_reset,
   input  wire [2:0]   i_select,
   output reg          o_tick
);
   reg  [WIDTH-1:0] div_r;
   wire [WIDTH-1:0] div_nxt = div_r + {{(WIDTH-1){1'b0}}, 1'b1};
   // four-bit shift amount so select 111 does not wrap to zero
   wire [3:0]       shamt   = {1'b0, i_select} + 4'd1;
   wire [WIDTH-1:0] lim     = (({{(WIDTH-1){1'b0}}, 1'b1}) << shamt) - 1'b1;
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         div_r  <= {WIDTH{1'b0}};
         o_tick <= 1'b0;
      end else begin
         if (div_r >= lim) begin
            div_r  <= {WIDTH{1'b0}};
            o_tick <= 1'b1;
         end else begin
            div_r  <= div_nxt;
            o_tick <= 1'b0;
         end
      end
   end
endmodule // tec8_prescaler
`default_nettype wire

// ===== tec8_timer.v
// 8-bit timer/event counter with apb register access
//
// The implementer's own choice: register access over APB.
`include "tec8_consts.vh"
`default_nettype none
module tec8_timer (
   input  wire         i_sys_clk,
   input  wire         i_reset,
   input  wire         i_psel,
   input  wire         i_penable,
   input  wire         i_pwrite,
   input  wire [11:0]  i_paddr,
   input  wire [31:0]  i_pwdata,
   input  wire [3:0]   i_pstrb,
   input  wire         i_event_input_pin,
   output reg  [31:0]  o_prdata,
   output reg          o_pready,
   output reg          o_pslverr,
   output reg          o_overflow_request_flag,
   output reg          o_irq_service,
   output reg          o_wakeup,
   output reg          o_divided_frequency_output
);
   reg  [7:0] count_r;
   reg  [7:0] preload_r;
   reg  [7:0] ctrl_r;
   reg        irq_en_r;
   reg        pin_s1_r;
   reg        pin_s2_r;
   reg        pin_d_r;
   reg        pulse_run_r;
   reg        pulse_done_r;
   wire       tick;
   wire [1:0] mode    = ctrl_r[`TEC8_BIT_MODE_LO+1:`TEC8_BIT_MODE_LO];
   wire       enable  = ctrl_r[`TEC8_BIT_ENABLE];
   wire       edge_sel = ctrl_r[`TEC8_BIT_EDGE];
   wire       access  = i_psel & i_penable & ~o_pready;
   wire       wr      = access & i_pwrite & i_pstrb[0];
   wire       rd      = access & ~i_pwrite;
   wire       hit_cnt = (i_paddr == {`TEC8_OFS_COUNT, 2'b00});
   wire       hit_ctl = (i_paddr == {`TEC8_OFS_CTRL, 2'b00});
   wire       hit_int = (i_paddr == {`TEC8_OFS_INTERRUPT_CONTROL_REG, 2'b00});
   wire       rise    = pin_s2_r & ~pin_d_r;
   wire       fall    = ~pin_s2_r & pin_d_r;
   // start edge depends on edge select
   wire       p_start = edge_sel ? rise : fall;
   wire       p_stop  = edge_sel ? fall : rise;
   wire       blk     = (i_psel & ~i_pwrite & hit_cnt);
   reg        cnt_en;
   always @* begin
      cnt_en = 1'b0;
      case (mode)
         `TEC8_MODE_EVENT: cnt_en = enable & (edge_sel ? fall : rise);
         `TEC8_MODE_TIMER: cnt_en = enable & tick;
         `TEC8_MODE_PULSE: cnt_en = pulse_run_r & tick & ~p_stop;
         default:          cnt_en = 1'b0;
      endcase
      if (blk) begin
         cnt_en = 1'b0;
      end
   end
   wire ovf = cnt_en & (count_r == 8'hFF);
   tec8_prescaler #(.WIDTH(`TEC8_PSC_WIDTH)) u_psc (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_select  (ctrl_r[`TEC8_BIT_PSC_LO+2:`TEC8_BIT_PSC_LO]),
      .o_tick    (tick)
   );
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_d_r  <= 1'b0;
      end else begin
         pin_s1_r <= i_event_input_pin;
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
      end
   end
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         count_r      <= 8'h00;
         preload_r    <= 8'h00;
         ctrl_r       <= `TEC8_CTRL_RESET;
         irq_en_r     <= 1'b0;
         pulse_run_r  <= 1'b0;
         pulse_done_r <= 1'b0;
         o_overflow_request_flag    <= 1'b0;
         o_irq_service              <= 1'b0;
         o_wakeup                   <= 1'b0;
         o_divided_frequency_output <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= access;
         o_pslverr <= access & ~(hit_cnt | hit_ctl | hit_int);
         if (rd) begin
            o_prdata <= hit_cnt ? {24'h00_0000, count_r} :
                        hit_ctl ? {24'h00_0000, ctrl_r} :
                        hit_int ? {26'h000_0000, o_overflow_request_flag, 4'h0, irq_en_r} :
                        32'h0000_0000;
         end
         if (ovf) begin
            count_r <= preload_r;
         end else if (cnt_en) begin
            count_r <= count_r + 8'h01;
         end
         if (ovf) begin
            o_divided_frequency_output <= ~o_divided_frequency_output;
         end
         o_wakeup <= ovf;
         o_irq_service <= ovf & irq_en_r;
         if (wr & hit_cnt) begin
            preload_r <= i_pwdata[7:0];
            if (!enable) begin
               count_r <= i_pwdata[7:0];
            end
         end
         if (wr & hit_int) begin
            irq_en_r <= i_pwdata[`TEC8_BIT_IRQ_EN];
         end
         if (ovf) begin
            o_overflow_request_flag <= 1'b1;
         end else if (wr & hit_int) begin
            o_overflow_request_flag <= i_pwdata[`TEC8_BIT_FLAG];
         end
         if (wr & hit_ctl) begin
            ctrl_r <= i_pwdata[7:0] & `TEC8_CTRL_MASK;
            if (i_pwdata[`TEC8_BIT_ENABLE]) begin
               pulse_done_r <= 1'b0;
            end
            pulse_run_r <= 1'b0;
         end else if (mode == `TEC8_MODE_PULSE && enable) begin
            // start on edge, once per enable
            if (!pulse_run_r && !pulse_done_r && p_start) begin
               pulse_run_r <= 1'b1;
            end else if (pulse_run_r && p_stop) begin
               pulse_run_r  <= 1'b0;
               pulse_done_r <= 1'b1;
               ctrl_r[`TEC8_BIT_ENABLE] <= 1'b0;
            end
         end
      end
   end
endmodule // tec8_timer
`default_nettype wire

// ===== tec8_properties.sv
// port assertions for the timer
`default_nettype none
module tec8_properties (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_overflow_request_flag,
   input wire logic o_irq_service,
   input wire logic o_wakeup,
   input wire logic o_divided_frequency_output
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);
   sequence s_take;
      i_psel && i_penable && !o_pready;
   endsequence
   a_ready_after_take: assert property (s_take |=> o_pready)
      else $error("no ready");
   a_ready_one_cycle: assert property (o_pready |=> !o_pready)
      else $error("ready held");
   a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
      else $error("stray ready");
   a_err_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("stray error");
   a_wake_sets_flag: assert property (o_wakeup |=> o_overflow_request_flag)
      else $error("flag missing");
   a_div_on_wake: assert property ($changed(o_divided_frequency_output) == o_wakeup)
      else $error("divider off");
   a_irq_needs_wake: assert property (o_irq_service |-> o_wakeup)
      else $error("stray service");
   a_wake_single: assert property (o_wakeup |=> !o_wakeup)
      else $error("wake held");
endmodule // tec8_properties
`default_nettype wire

// ===== tec8_pin_model.sv
// pulse source on the event pin
`default_nettype none
module tec8_pin_model (
   input wire logic i_sys_clk,
   output var logic o_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_pin = 1'b0;
   task automatic pulse(input logic lvl, input int len);
      o_pin <= lvl;
      repeat (len) @(posedge i_sys_clk);
      o_pin <= ~lvl;
      repeat (len) @(posedge i_sys_clk);
   endtask
endmodule // tec8_pin_model
`default_nettype wire

// ===== tec8_timer_tb_top.sv
// bench for the 8-bit timer
`default_nettype none
module tec8_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, ef, rdy, err, flag, irq, wake, divo, pin;
   logic [11:0] adr = 0;
   logic [31:0] wd = 0, rdat, rd;
   int num_errors = 0, comparisons = 0;
   tec8_timer dut_u (.i_sys_clk(clk), .i_reset(rst), .i_psel(sel), .i_penable(en),
      .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd), .i_pstrb(4'hF), .i_event_input_pin(pin),
      .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .o_overflow_request_flag(flag),
      .o_irq_service(irq), .o_wakeup(wake), .o_divided_frequency_output(divo));
   tec8_pin_model pin_u (.i_sys_clk(clk), .o_pin(pin));
   initial forever #2.5 clk = ~clk;
   task automatic check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      sel <= 1'b1;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      en <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = rdat;
      ef = err;
      sel <= 1'b0;
      en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_wake(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wake !== 1'b1 && n < 600);
   endtask
   // byte addresses: four times the register index
   localparam logic [11:0] A_CNT = 12'h034;
   localparam logic [11:0] A_CTL = 12'h038;
   localparam logic [11:0] A_INT = 12'h040;
   task automatic t_event;
      apb(0, A_CTL, 0);
      check(rd, 32'h0000_0008);
      apb(0, 12'h020, 0);
      check({31'h0, ef}, 32'h1);
      apb(1, A_CNT, 32'h0000_00FE);
      apb(1, A_CTL, 32'h0000_0050);
      apb(0, A_CNT, 0);
      check(rd, 32'h0000_00FE);
      pin_u.pulse(1'b1, 4);
      pin_u.pulse(1'b1, 4);
      apb(0, A_CNT, 0);
      check(rd, 32'h0000_00FE);
      check({31'h0, flag}, 32'h1);
      apb(0, A_CTL, 0);
      check(rd, 32'h0000_0050);
      apb(1, A_CTL, 32'h0000_0058);
      pin_u.pulse(1'b1, 4);
      apb(0, A_CNT, 0);
      check(rd, 32'h0000_00FF);
      $display("event done");
   endtask
   task automatic t_prescale;
      int n;
      logic d;
      apb(1, A_INT, 32'h0000_0001);
      for (int p = 0; p < 8; p++) begin
         apb(1, A_CTL, 32'h0000_0000);
         apb(1, A_CNT, 32'h0000_00FF);
         apb(1, A_CTL, 32'h0000_0090 + p);
         wait_wake(n);
         d = divo;
         wait_wake(n);
         check(n, 2 << p);
         check({31'h0, irq}, 32'h1);
         check({31'h0, divo}, {31'h0, ~d});
      end
      // long tick at divide by 256 leaves room for the update
      apb(1, A_CNT, 32'h0000_0080);
      apb(0, A_CNT, 0);
      check(rd, 32'h0000_00FF);
      wait_wake(n);
      apb(0, A_CNT, 0);
      check(rd, 32'h0000_0080);
      $display("prescale done");
   endtask
   task automatic t_pulse;
      logic [31:0] m;
      apb(1, A_CTL, 32'h0000_0000);
      apb(1, A_CNT, 32'h0000_0000);
      apb(1, A_CTL, 32'h0000_00D8);
      pin_u.pulse(1'b1, 20);
      apb(0, A_CTL, 0);
      check(rd, 32'h0000_00C8);
      apb(0, A_CNT, 0);
      m = rd;
      check({31'h0, m > 8 && m < 12}, 32'h1);
      pin_u.pulse(1'b1, 20);
      apb(1, A_CTL, 32'h0000_00D0);
      repeat (10) @(posedge clk);
      apb(0, A_CNT, 0);
      check(rd, m);
      $display("pulse done");
   endtask
   task automatic print_verdict;
      $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_event;
      t_prescale;
      t_pulse;
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      print_verdict;
   end
endmodule // tec8_timer_tb_top
bind tec8_timer tec8_properties chk_u (.i_sys_clk, .i_reset, .i_psel, .i_penable, .o_pready,
   .o_pslverr, .o_overflow_request_flag, .o_irq_service, .o_wakeup, .o_divided_frequency_output);
`default_nettype wire
